/* cell_gating_pkg.sv */
// constants for the logic cell input gating and polarity stage
package cell_gating_pkg;
   // apb geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   // register byte addresses
   localparam logic [11:0] CELL_CONTROL_ADDR = 12'h000;
   localparam logic [11:0] CELL_POLARITY_CONTROL_ADDR = 12'h004;
   localparam logic [11:0] DATA_ONE_SOURCE_SELECT_ADDR = 12'h008;
   localparam logic [11:0] SOURCE_SELECT_STRIDE = 12'h004;
   localparam logic [11:0] GATE_ZERO_TERM_ENABLE_ADDR = 12'h018;
   // data selection
   localparam int unsigned NUM_DATA = 4;
   localparam int unsigned SEL_W = 6;
   localparam int unsigned NUM_SOURCES = 64;
   localparam int unsigned NUM_GATES = 4;
   // cell control fields
   localparam int unsigned CELL_ENABLE_BIT_POS = 7;
   localparam int unsigned CELL_OUTPUT_STATUS_POS = 5;
   localparam logic [7:0] CELL_CONTROL_RESET = 8'h00;
   // polarity fields
   localparam int unsigned CELL_OUTPUT_INVERT_POS = 7;
   localparam logic [7:0] POLARITY_WRITE_MASK = 8'h8f;
   // selector field mask, bits 7:6 unimplemented
   localparam logic [7:0] SOURCE_SELECT_MASK = 8'h3f;
endpackage

/* cell_input_gating.sv */
// apb register file, data selection, gate zero combining and polarity stage
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps

// Behaviour
// - output invert bit 7 set inverts the cell result before driving the output
// - polarity bits 0-3 invert gates 0-3 where applied to the function
// - polarity bits 6-4 have no function and read zero
// - first selector bits 5-0 choose the source of data one
// - second selector bits 5-0 choose the source of data two
// - third selector bits 5-0 choose the source of data three
// - fourth selector bits 5-0 choose the source of data four
// - selector bits 7-6 are unimplemented and read zero
// - gate zero odd enable bits gate true data four/three/two/one in
// - gate zero even enable bits gate inverted data four/three/two/one in
// - cell enable clear forces the cell output to zero
// - reset clears only the control register, other settings are kept
// - output status bit shows the cell output after output inversion
module cell_input_gating (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cell_gating_pkg::ADDR_W-1:0] paddr,
   input wire logic [cell_gating_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [cell_gating_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [cell_gating_pkg::NUM_SOURCES-1:0] data_sources,
   input wire logic gate_one_raw,
   input wire logic gate_two_raw,
   input wire logic gate_three_raw,
   input wire logic cell_function_result,
   output logic selected_data_one,
   output logic selected_data_two,
   output logic selected_data_three,
   output logic selected_data_four,
   output logic gate_zero_applied,
   output logic gate_one_applied,
   output logic gate_two_applied,
   output logic gate_three_applied,
   output logic cell_enable,
   output logic cell_output_signal
);
   import cell_gating_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [REG_W-1:0] control_q;
   logic [REG_W-1:0] polarity_q;
   logic [SEL_W-1:0] source_q [NUM_DATA];
   logic [REG_W-1:0] gate_zero_enable_q;
   logic [NUM_DATA-1:0] selected_q;
   logic [NUM_GATES-1:0] gate_applied_q;
   logic cell_output_q;
   logic [DATA_W-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic setup_phase;
   logic write_commit;
   logic [NUM_DATA-1:0] source_hit;
   logic addr_mapped;
   logic [REG_W-1:0] read_value;
   logic [NUM_DATA-1:0] gate_zero_terms;
   logic gate_zero_raw;
   logic [NUM_GATES-1:0] gate_raw;
   logic cell_output_d;
   logic cell_output_invert;
   logic cell_enable_bit;

   ////////////////////////////////////////////////////////////////////////////////
   // apb handshake

   // setup cycle and committing access edge
   assign setup_phase = psel && !penable;
   assign write_commit = psel && penable && pready_q && pwrite;

   // per-selector address match
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DATA; gi++) begin : g_hit
         assign source_hit[gi] = (paddr == DATA_ONE_SOURCE_SELECT_ADDR
            + ADDR_W'(gi) * SOURCE_SELECT_STRIDE);
      end
   endgenerate

   // decode of the implemented words
   assign addr_mapped = (paddr == CELL_CONTROL_ADDR)
      || (paddr == CELL_POLARITY_CONTROL_ADDR)
      || (paddr == GATE_ZERO_TERM_ENABLE_ADDR)
      || (|source_hit);

   // read mux, unimplemented bits come back as zero
   always_comb begin
      read_value = '0;
      if (paddr == CELL_CONTROL_ADDR) begin
         read_value[CELL_ENABLE_BIT_POS] = control_q[CELL_ENABLE_BIT_POS];
         read_value[CELL_OUTPUT_STATUS_POS] = cell_output_q;
      end else if (paddr == CELL_POLARITY_CONTROL_ADDR) begin
         read_value = polarity_q & POLARITY_WRITE_MASK;
      end else if (paddr == GATE_ZERO_TERM_ENABLE_ADDR) begin
         read_value = gate_zero_enable_q;
      end else begin
         for (int k = 0; k < NUM_DATA; k++) begin
            if (source_hit[k]) begin
               read_value = {2'h0, source_q[k]};
            end
         end
      end
   end

   // one-cycle access phase, ready raised after every setup cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= setup_phase;
         pslverr_q <= setup_phase && !addr_mapped;
         if (setup_phase && !pwrite && addr_mapped) begin
            prdata_q <= {{(DATA_W-REG_W){1'b0}}, read_value};
         end else if (setup_phase) begin
            prdata_q <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   // control register, the only one cleared by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         control_q <= CELL_CONTROL_RESET;
      end else if (write_commit && pstrb[0] && paddr == CELL_CONTROL_ADDR) begin
         control_q <= '0;
         control_q[CELL_ENABLE_BIT_POS] <= pwdata[CELL_ENABLE_BIT_POS];
      end
   end

   // polarity register, kept through reset
   always_ff @(posedge clk) begin
      if (write_commit && pstrb[0] && paddr == CELL_POLARITY_CONTROL_ADDR) begin
         polarity_q <= pwdata[REG_W-1:0] & POLARITY_WRITE_MASK;
      end
   end

   // gate zero term enables, kept through reset
   always_ff @(posedge clk) begin
      if (write_commit && pstrb[0] && paddr == GATE_ZERO_TERM_ENABLE_ADDR) begin
         gate_zero_enable_q <= pwdata[REG_W-1:0];
      end
   end

   // source selectors and selected data, one per data signal
   generate
      for (gi = 0; gi < NUM_DATA; gi++) begin : g_sel
         always_ff @(posedge clk) begin
            if (write_commit && pstrb[0] && source_hit[gi]) begin
               source_q[gi] <= pwdata[SEL_W-1:0];
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               selected_q[gi] <= 1'b0;
            end else begin
               selected_q[gi] <= data_sources[source_q[gi]];
            end
         end
         // odd bit true term, even bit inverted term
         assign gate_zero_terms[gi] = (gate_zero_enable_q[2*gi+1] && selected_q[gi])
            || (gate_zero_enable_q[2*gi] && !selected_q[gi]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // gates and output

   assign gate_zero_raw = |gate_zero_terms;
   assign gate_raw = {gate_three_raw, gate_two_raw, gate_one_raw, gate_zero_raw};
   assign cell_output_invert = polarity_q[CELL_OUTPUT_INVERT_POS];
   assign cell_enable_bit = control_q[CELL_ENABLE_BIT_POS];

   // gate polarity applied before the logic function
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_applied_q <= '0;
      end else begin
         gate_applied_q <= gate_raw ^ polarity_q[NUM_GATES-1:0];
      end
   end

   // output inversion, then forced low while disabled
   assign cell_output_d = cell_enable_bit && (cell_function_result ^ cell_output_invert);

   always_ff @(posedge clk) begin
      if (rst) begin
         cell_output_q <= 1'b0;
      end else begin
         cell_output_q <= cell_output_d;
      end
   end

   // port drive
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign selected_data_one = selected_q[0];
   assign selected_data_two = selected_q[1];
   assign selected_data_three = selected_q[2];
   assign selected_data_four = selected_q[3];
   assign gate_zero_applied = gate_applied_q[0];
   assign gate_one_applied = gate_applied_q[1];
   assign gate_two_applied = gate_applied_q[2];
   assign gate_three_applied = gate_applied_q[3];
   assign cell_enable = control_q[CELL_ENABLE_BIT_POS];
   assign cell_output_signal = cell_output_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_output_polarity: assert property (
      cell_enable_bit |=> cell_output_q == $past(cell_function_result ^ cell_output_invert))
      else $error("cell output polarity wrong");

   // per gate, each polarity checked both ways; skipped while settings are unwritten
   chk_gate_polarity: assert property (
      (!rst && gate_raw[0] != polarity_q[0] |=> gate_applied_q[0])
      and (!rst && gate_raw[0] == polarity_q[0] |=> !gate_applied_q[0])
      and (!rst && gate_raw[1] != polarity_q[1] |=> gate_applied_q[1])
      and (!rst && gate_raw[1] == polarity_q[1] |=> !gate_applied_q[1])
      and (!rst && gate_raw[2] != polarity_q[2] |=> gate_applied_q[2])
      and (!rst && gate_raw[2] == polarity_q[2] |=> !gate_applied_q[2])
      and (!rst && gate_raw[3] != polarity_q[3] |=> gate_applied_q[3])
      and (!rst && gate_raw[3] == polarity_q[3] |=> !gate_applied_q[3]))
      else $error("gate polarity wrong");

   chk_pol_reserved_zero: assert property (
      setup_phase && !pwrite && paddr == CELL_POLARITY_CONTROL_ADDR
      |=> prdata_q[6:4] == 3'h0 && prdata_q[DATA_W-1:REG_W] == '0)
      else $error("polarity reserved bits not zero");

   chk_data_one_select: assert property (
      (!rst && data_sources[source_q[0]] |=> selected_q[0])
      and (!rst && !data_sources[source_q[0]] |=> !selected_q[0]))
      else $error("data one selection wrong");

   chk_data_two_select: assert property (
      (!rst && data_sources[source_q[1]] |=> selected_q[1])
      and (!rst && !data_sources[source_q[1]] |=> !selected_q[1]))
      else $error("data two selection wrong");

   chk_data_three_select: assert property (
      (!rst && data_sources[source_q[2]] |=> selected_q[2])
      and (!rst && !data_sources[source_q[2]] |=> !selected_q[2]))
      else $error("data three selection wrong");

   chk_data_four_select: assert property (
      (!rst && data_sources[source_q[3]] |=> selected_q[3])
      and (!rst && !data_sources[source_q[3]] |=> !selected_q[3]))
      else $error("data four selection wrong");

   chk_sel_reserved_zero: assert property (
      setup_phase && !pwrite && (|source_hit) |=> prdata_q[7:6] == 2'h0)
      else $error("selector reserved bits not zero");

   chk_gate_true_terms: assert property (
      !rst && ((gate_zero_enable_q[7] && selected_q[3]) || (gate_zero_enable_q[5] && selected_q[2])
      || (gate_zero_enable_q[3] && selected_q[1]) || (gate_zero_enable_q[1] && selected_q[0]))
      |=> gate_applied_q[0] == !$past(polarity_q[0]))
      else $error("true term not gated into gate zero");

   chk_gate_neg_terms: assert property (
      !rst && ((gate_zero_enable_q[6] && !selected_q[3]) || (gate_zero_enable_q[4] && !selected_q[2])
      || (gate_zero_enable_q[2] && !selected_q[1]) || (gate_zero_enable_q[0] && !selected_q[0]))
      |=> gate_applied_q[0] == !$past(polarity_q[0]))
      else $error("inverted term not gated into gate zero");

   chk_disable_forces_low: assert property (
      !cell_enable_bit ##1 !cell_enable_bit |-> !cell_output_q)
      else $error("disabled cell output not low");

   // armed on the first edge of a later reset, when the settings hold written values
   chk_reset_keeps_config: assert property (@(posedge clk) disable iff (1'b0)
      rst && !$past(rst) |=> polarity_q == $past(polarity_q)
      && gate_zero_enable_q == $past(gate_zero_enable_q) && control_q == CELL_CONTROL_RESET)
      else $error("reset effect on registers wrong");

   chk_status_reflects_out: assert property (
      setup_phase && !pwrite && paddr == CELL_CONTROL_ADDR
      |=> prdata_q[CELL_OUTPUT_STATUS_POS] == $past(cell_output_q))
      else $error("status bit differs from cell output");

   chk_gate_no_terms: assert property (
      !rst && gate_zero_enable_q == 8'h00 |=> gate_applied_q[0] == $past(polarity_q[0]))
      else $error("gate zero not zero with no terms");

   cov_enabled_high: cover property (cell_enable_bit ##1 cell_output_q);
   cov_inverted_out: cover property (cell_enable_bit && cell_output_invert ##1 cell_output_q);
   cov_unmapped_err: cover property (pslverr_q && pready_q);
   cov_write_commit: cover property (write_commit && paddr == GATE_ZERO_TERM_ENABLE_ADDR);

endmodule

/* cell_input_gating_tb.sv */
// self-checking bench for the cell input gating and polarity stage
`timescale 1ns/100ps
module cell_input_gating_tb;
   import cell_gating_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic gate_one_raw, gate_two_raw, gate_three_raw, cell_function_result;
   logic cell_enable, cell_output_signal;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [3:0] pstrb, sel_out, app;
   logic [NUM_SOURCES-1:0] data_sources;
   int failures, checked;

   cell_input_gating i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .data_sources(data_sources),
      .gate_one_raw(gate_one_raw), .gate_two_raw(gate_two_raw),
      .gate_three_raw(gate_three_raw), .cell_function_result(cell_function_result),
      .selected_data_one(sel_out[0]), .selected_data_two(sel_out[1]),
      .selected_data_three(sel_out[2]), .selected_data_four(sel_out[3]),
      .gate_zero_applied(app[0]), .gate_one_applied(app[1]), .gate_two_applied(app[2]),
      .gate_three_applied(app[3]), .cell_enable(cell_enable),
      .cell_output_signal(cell_output_signal));

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
         input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdx(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 8'h00, 4'h1);
      chk(rd, e);
      chk(err, 1'b0);
   endtask

   function automatic logic [11:0] sel_addr(input int k);
      return DATA_ONE_SOURCE_SELECT_ADDR + SOURCE_SELECT_STRIDE * 12'(k);
   endfunction

   // let the two-stage data path settle
   task automatic settle();
      repeat (4) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_regs();
      apb(1'b1, CELL_POLARITY_CONTROL_ADDR, 8'hff, 4'h1);
      rdx(CELL_POLARITY_CONTROL_ADDR, 32'h8f);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, sel_addr(k), 8'hff, 4'h1);
         rdx(sel_addr(k), 32'h3f);
      end
      apb(1'b1, GATE_ZERO_TERM_ENABLE_ADDR, 8'ha5, 4'h1);
      rdx(GATE_ZERO_TERM_ENABLE_ADDR, 32'ha5);
      apb(1'b1, GATE_ZERO_TERM_ENABLE_ADDR, 8'h5a, 4'h0);
      rdx(GATE_ZERO_TERM_ENABLE_ADDR, 32'ha5);
      apb(1'b1, CELL_CONTROL_ADDR, 8'h7f, 4'h1);
      rdx(CELL_CONTROL_ADDR, 32'h00);
      apb(1'b0, 12'h01c, 8'h00, 4'h1);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("test_regs done");
   endtask

   task automatic test_select();
      logic [5:0] sv [4] = '{6'h3f, 6'h00, 6'h2a, 6'h15};
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, sel_addr(k), {2'b11, sv[k]}, 4'h1);
         rdx(sel_addr(k), {26'h0, sv[k]});
         data_sources <= 64'h1 << sv[k];
         settle();
         chk(sel_out[k], 1'b1);
         data_sources <= ~(64'h1 << sv[k]);
         settle();
         chk(sel_out[k], 1'b0);
      end
      $display("test_select done");
   endtask

   task automatic test_gate();
      logic [3:0] d;
      logic e;
      d = 4'b0101;
      for (int k = 0; k < 4; k++) apb(1'b1, sel_addr(k), 8'(k), 4'h1);
      apb(1'b1, CELL_POLARITY_CONTROL_ADDR, 8'h00, 4'h1);
      data_sources <= {60'h0, d};
      gate_one_raw <= 1'b1;
      gate_two_raw <= 1'b0;
      gate_three_raw <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, GATE_ZERO_TERM_ENABLE_ADDR, 8'h01 << i, 4'h1);
         settle();
         e = i[0] ? d[i / 2] : !d[i / 2];
         chk(app[0], e);
      end
      chk(app[3:1], 3'b101);
      apb(1'b1, GATE_ZERO_TERM_ENABLE_ADDR, 8'h00, 4'h1);
      apb(1'b1, CELL_POLARITY_CONTROL_ADDR, 8'h0f, 4'h1);
      settle();
      chk(app, 4'b0101);
      apb(1'b1, GATE_ZERO_TERM_ENABLE_ADDR, 8'h03, 4'h1);
      settle();
      chk(app[0], 1'b0);
      $display("test_gate done");
   endtask

   task automatic test_output();
      logic e;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, CELL_CONTROL_ADDR, {c[2], 7'h00}, 4'h1);
         apb(1'b1, CELL_POLARITY_CONTROL_ADDR, {c[1], 7'h00}, 4'h1);
         cell_function_result <= c[0];
         settle();
         e = c[2] & (c[0] ^ c[1]);
         chk(cell_enable, c[2]);
         chk(cell_output_signal, e);
         rdx(CELL_CONTROL_ADDR, {24'h0, c[2], 1'b0, e, 5'h00});
      end
      $display("test_output done");
   endtask

   task automatic test_reset();
      apb(1'b1, CELL_POLARITY_CONTROL_ADDR, 8'h0a, 4'h1);
      apb(1'b1, GATE_ZERO_TERM_ENABLE_ADDR, 8'h3c, 4'h1);
      apb(1'b1, sel_addr(2), 8'h2d, 4'h1);
      apb(1'b1, CELL_CONTROL_ADDR, 8'h80, 4'h1);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chk(cell_enable, 1'b0);
      rdx(CELL_CONTROL_ADDR, 32'h00);
      rdx(CELL_POLARITY_CONTROL_ADDR, 32'h0a);
      rdx(GATE_ZERO_TERM_ENABLE_ADDR, 32'h3c);
      rdx(sel_addr(2), 32'h2d);
      $display("test_reset done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // verdict, clock, watchdog and main sequence
   task automatic give_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
      data_sources = '0;
      gate_one_raw = 1'b0;
      gate_two_raw = 1'b0;
      gate_three_raw = 1'b0;
      cell_function_result = 1'b0;
      failures = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      test_regs();
      test_select();
      test_gate();
      test_output();
      test_reset();
      give_verdict();
   end
endmodule
